// ==== sim/path_snc_protection_selector_tb.sv ====
/*
  Self-checking bench for psp_selector with three far-end stream models.
  Assumes shortened timers: 1 ms is 10 cycles, basic switch 50 cycles, 1 minute 50 cycles.
*/
`default_nettype none
module path_snc_protection_selector_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in, rst_in, ce_in, tx_clk_in, tx_frame_start_in, tx_work_clk_out, tx_work_frame_start_out;
  logic tx_prot_clk_out, tx_prot_frame_start_out, work_clk_in, work_frame_start_in, work_server_signal_fail_in;
  logic work_trail_signal_fail_in, work_trail_signal_degrade_in, prot_clk_in, prot_frame_start_in;
  logic prot_server_signal_fail_in, prot_trail_signal_fail_in, prot_trail_signal_degrade_in, rx_frame_start_out;
  logic rx_valid_out, rx_ready_in, protection_type_in, revertive_in, on_protection_out, wtr_running_out;
  logic work_fail_out, prot_fail_out, go, lastp, frz, ok;
  logic [7:0] tx_data_in, tx_work_data_out, tx_prot_data_out, work_data_in, prot_data_in, rx_data_out, w, frz_d;
  logic [3:0] wait_to_restore_interval_min_in;
  logic [13:0] holdoff_ms_in;
  logic [1:0] ext_cmd_in;
  logic [15:0] seed, seed2;
  integer n_errors, n_checks, n_cyc, st_n, i;
  psp_selector #(.DATA_W(8), .MS_CYCLES(10), .BASE_SWITCH_CYCLES(50), .MIN_MS(5)) u_dut (.*);
  psp_far_end #(.TAG(8'h40), .PH(3)) u_tx (.clk_out(tx_clk_in), .data_out(tx_data_in), .fs_out(tx_frame_start_in));
  psp_far_end #(.TAG(8'h00), .PH(7)) u_wk (.clk_out(work_clk_in), .data_out(work_data_in), .fs_out(work_frame_start_in));
  psp_far_end #(.TAG(8'h80), .PH(12)) u_pt (.clk_out(prot_clk_in), .data_out(prot_data_in), .fs_out(prot_frame_start_in));
  function automatic logic [15:0] lf(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic st(input integer n, input logic e);
    repeat (n) @(posedge clk_sys_in);
    #1;
    chk(on_protection_out, e);
  endtask
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // Receiver stalls at random; each word taken after 40 cycles of steady selection must come from the active connection.
  always @(posedge clk_sys_in)
  begin
    if (on_protection_out !== lastp)
      st_n = 0;
    else
      st_n = st_n + 1;
    lastp = on_protection_out;
    if (go && st_n > 40 && rx_valid_out && rx_ready_in)
      chk(rx_data_out[7:6], {on_protection_out, 1'b0});
    #1;
    seed = lf(seed);
    rx_ready_in = |seed[1:0];
  end
  // A run that outlives its ceiling counts as a mismatch.
  always @(posedge clk_sys_in)
  begin
    n_cyc++;
    if (n_cyc == 5000)
    begin
      n_errors++;
      close_out();
    end
  end
  // Link words are only compared when the clock enable stood high for the whole word.
  always @(posedge tx_clk_in)
  begin
    w = tx_data_in;
    ok = go && !frz;
    #90;
    if (ok && !frz)
      chk({tx_work_data_out, tx_prot_data_out}, {w, w});
  end
  initial
  begin
    {n_errors, n_checks, n_cyc, st_n} = '0;
    {go, lastp, frz, protection_type_in, revertive_in, ext_cmd_in} = '0;
    {work_server_signal_fail_in, work_trail_signal_fail_in, work_trail_signal_degrade_in} = '0;
    {prot_server_signal_fail_in, prot_trail_signal_fail_in, prot_trail_signal_degrade_in} = '0;
    {rst_in, ce_in, rx_ready_in} = 3'h7;
    wait_to_restore_interval_min_in = 4'h1;
    holdoff_ms_in = 14'h0002;
    seed = 16'h8931;
    seed2 = 16'h8931;
    repeat (8) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    st(40, 1'b0);
    go = 1'b1;
    // Force, force back, manual, then clear, which must not revert in non-revertive mode.
    for (i = 0; i < 4; i++)
    begin
      ext_cmd_in = 2'(i + 1);
      st(8, 1'(4'hD >> i));
    end
    ext_cmd_in = 2'h2;
    st(8, 1'b0);
    ext_cmd_in = 2'h0;
    st(8, 1'b0);
    $display("commands done");
    revertive_in = 1'b1;
    {work_server_signal_fail_in, prot_server_signal_fail_in} = 2'h3;
    st(120, 1'b0);
    prot_server_signal_fail_in = 1'b0;
    st(60, 1'b0);
    st(20, 1'b1);
    work_server_signal_fail_in = 1'b0;
    st(10, 1'b1);
    chk(wtr_running_out, 1'b1);
    st(20, 1'b1);
    work_server_signal_fail_in = 1'b1;
    st(10, 1'b1);
    chk(wtr_running_out, 1'b0);
    work_server_signal_fail_in = 1'b0;
    st(30, 1'b1);
    st(40, 1'b0);
    $display("inherent done");
    {protection_type_in, revertive_in, work_server_signal_fail_in} = 3'h5;
    st(100, 1'b0);
    {work_server_signal_fail_in, work_trail_signal_degrade_in} = 2'h1;
    st(90, 1'b1);
    work_trail_signal_degrade_in = 1'b0;
    st(100, 1'b1);
    prot_trail_signal_degrade_in = 1'b1;
    st(10, 1'b0);
    work_trail_signal_fail_in = 1'b1;
    st(100, 1'b0);
    prot_trail_signal_degrade_in = 1'b0;
    st(90, 1'b1);
    {work_trail_signal_fail_in, prot_trail_signal_fail_in} = 2'h1;
    st(10, 1'b0);
    prot_trail_signal_fail_in = 1'b0;
    $display("nonintrusive done");
    for (i = 0; i < 8; i++)
    begin
      seed2 = lf(seed2);
      holdoff_ms_in = {10'h000, seed2[3:0]};
      wait_to_restore_interval_min_in = seed2[7:4];
      revertive_in = seed2[8];
      st(100, 1'b0);
    end
    $display("idle setup done");
    // With the clock enable low the bridge and the selector must hold still.
    frz = 1'b1;
    ce_in = 1'b0;
    frz_d = tx_work_data_out;
    st(40, 1'b0);
    chk(tx_work_data_out, frz_d);
    ce_in = 1'b1;
    st(30, 1'b0);
    frz = 1'b0;
    $display("freeze done");
    close_out();
  end
endmodule
`default_nettype wire

// ==== sim/psp_far_end.sv ====
/*
  Model of an adaptation function presenting a path stream: link clock, data and frame start.
  Assumes the receiver samples on the rising link edge; data moves on the falling one.
*/
`default_nettype none
module psp_far_end #(
  parameter logic [7:0] TAG = 8'h00,
  parameter int PH = 3
) (
  // Link stream
  output logic clk_out,
  output logic [7:0] data_out,
  output logic fs_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // The two top data bits name the source so the receiver can tell streams apart.
  initial
  begin
    clk_out = 1'b0;
    data_out = TAG;
    fs_out = 1'b1;
    #PH;
    forever
    begin
      #80;
      clk_out = ~clk_out;
      if (!clk_out)
      begin
        data_out = TAG | ((data_out + 8'h01) & 8'h3F);
        fs_out = (data_out[2:0] == 3'h0);
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/psp_selector_chk.sv ====
/*
  Port checker for the path protection selector, bound to psp_selector.
  Assumes ce_in drops only while the selector is idle and the timers are shortened.
*/
`default_nettype none
module psp_selector_chk #(
  parameter BASE_SWITCH_CYCLES = 50,
  parameter MS_CYCLES = 10
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Watched ports
  input wire logic [7:0] tx_work_data_out,
  input wire logic [7:0] tx_prot_data_out,
  input wire logic work_server_signal_fail_in,
  input wire logic work_trail_signal_degrade_in,
  input wire logic protection_type_in,
  input wire logic revertive_in,
  input wire logic [13:0] holdoff_ms_in,
  input wire logic [1:0] ext_cmd_in,
  input wire logic [7:0] rx_data_out,
  input wire logic rx_valid_out,
  input wire logic rx_ready_in,
  input wire logic on_protection_out,
  input wire logic wtr_running_out,
  input wire logic work_fail_out,
  input wire logic prot_fail_out
);
  timeunit 1ns;
  timeprecision 1ns;
  integer bad_q;
  // Counts cycles in which only the working connection has been reported bad.
  always @(posedge clk_sys_in)
  begin
    if (rst_in || !work_fail_out || prot_fail_out || on_protection_out)
      bad_q <= 0;
    else
      bad_q <= bad_q + 1;
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  a_tx_bridge_same: assert property (tx_work_data_out == tx_prot_data_out)
    else $error("bridge copies differ");
  a_force_prot_cmd: assert property (ext_cmd_in == 2'h1 |-> ##[1:4] on_protection_out)
    else $error("force to protection ignored");
  a_force_work_cmd: assert property (ext_cmd_in == 2'h2 |-> ##[1:4] !on_protection_out)
    else $error("force to working ignored");
  a_holdoff_min_wait: assert property ($rose(on_protection_out) && ext_cmd_in == 2'h0 |->
    bad_q + 3 >= BASE_SWITCH_CYCLES + holdoff_ms_in * MS_CYCLES) else $error("switch before hold-off");
  a_holdoff_max_wait: assert property (ext_cmd_in == 2'h0 |->
    bad_q <= BASE_SWITCH_CYCLES + holdoff_ms_in * MS_CYCLES + 4) else $error("switch too late");
  a_rx_word_held: assert property (rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out))
    else $error("stalled word lost");
  a_nonrev_stays: assert property (!revertive_in && on_protection_out && ext_cmd_in == 2'h0 |->
    ##1 (on_protection_out || prot_fail_out) or ##[1:3] prot_fail_out) else $error("left protection");
  a_ssf_criterion: assert property ((!protection_type_in && work_server_signal_fail_in) [*6] |->
    work_fail_out) else $error("server fail not used");
  a_tsd_criterion: assert property ((protection_type_in && work_trail_signal_degrade_in) [*6] |->
    work_fail_out) else $error("trail degrade not used");
  a_wtr_overridden: assert property (wtr_running_out && work_fail_out |->
    ##[0:2] (!wtr_running_out && on_protection_out)) else $error("wait timer not overridden");
  c_auto_switch: cover property ($rose(on_protection_out) && ext_cmd_in == 2'h0);
  c_wtr_return: cover property ($fell(wtr_running_out) && !on_protection_out);
  c_rx_stall: cover property (rx_valid_out && !rx_ready_in);
endmodule
bind psp_selector psp_selector_chk #(.BASE_SWITCH_CYCLES(BASE_SWITCH_CYCLES), .MS_CYCLES(MS_CYCLES)) u_chk (.*);
`default_nettype wire

// ==== src/psp_map.vh ====
/*
  Constants for the path protection selector: timing figures, command codes and
  operation settings.
  Assumes a 100 MHz system clock.
*/
`ifndef PSP_MAP_VH
`define PSP_MAP_VH

`define PSP_CLK_HZ 100000000
`define PSP_BASE_SWITCH_MS 100
`define PSP_HOLDOFF_MAX_MS 10000
`define PSP_WTR_MIN_MIN 5
`define PSP_WTR_MAX_MIN 12
`define PSP_WTR_DEFAULT_MIN 5
`define PSP_MS_CYCLES (`PSP_CLK_HZ / 1000)
`define PSP_BASE_SWITCH_CYCLES (`PSP_BASE_SWITCH_MS * `PSP_MS_CYCLES)
`define PSP_MIN_MS (60 * 1000)
`define PSP_CMD_CLEAR 2'h0
`define PSP_CMD_FORCE_PROT 2'h1
`define PSP_CMD_FORCE_WORK 2'h2
`define PSP_CMD_MANUAL_PROT 2'h3
`define PSP_PROT_INHERENT 1'b0
`define PSP_PROT_NONINTRUSIVE 1'b1

`endif

// ==== src/psp_selector.v ====
/*
  Path subnetwork connection 1+1 protection selector: permanent transmit bridge
  and receive selector with hold-off, wait-to-restore and management commands.
  Assumes the adaptation and monitor functions present data with a link clock
  and frame start from outside this clock domain, and that management drives
  the command and setup ports from logic on clk_sys_in.
*/
// What this block does
// - Transmit side copies outgoing data and timing to working and protection outputs.
// - Automatic switching weighs defects of working and protection together.
// - Inherent mode uses each side's server signal fail as criterion.
// - Non-intrusive mode uses trail signal fail and degrade instead.
// - No switch active: forward working signal, discard protection signal.
// - Switch in effect: forward protection signal, never the working one.
// - Management commands can force or request a switch.
// - Switch completes 100 ms plus provisioned hold-off after criterion detection.
// - Revertive mode returns traffic to working after it recovers.
// - Recovered connection waits a settable 0-15 minute interval before reuse.
// - New fail or degrade during wait-to-restore overrides the timer.
// - Setup changes while idle do not disturb traffic.
`default_nettype none
`include "psp_map.vh"

module psp_selector #(
  parameter DATA_W = 8,
  parameter MS_CYCLES = `PSP_MS_CYCLES,
  parameter BASE_SWITCH_CYCLES = `PSP_BASE_SWITCH_CYCLES,
  parameter MIN_MS = `PSP_MIN_MS
) (
  // Clock, reset, enable
  input wire clk_sys_in,
  input wire rst_in,
  input wire ce_in,
  // Transmit side from the path source
  input wire [DATA_W-1:0] tx_data_in,
  input wire tx_clk_in,
  input wire tx_frame_start_in,
  output reg [DATA_W-1:0] tx_work_data_out,
  output reg tx_work_clk_out,
  output reg tx_work_frame_start_out,
  output reg [DATA_W-1:0] tx_prot_data_out,
  output reg tx_prot_clk_out,
  output reg tx_prot_frame_start_out,
  // Receive working connection
  input wire [DATA_W-1:0] work_data_in,
  input wire work_clk_in,
  input wire work_frame_start_in,
  input wire work_server_signal_fail_in,
  input wire work_trail_signal_fail_in,
  input wire work_trail_signal_degrade_in,
  // Receive protection connection
  input wire [DATA_W-1:0] prot_data_in,
  input wire prot_clk_in,
  input wire prot_frame_start_in,
  input wire prot_server_signal_fail_in,
  input wire prot_trail_signal_fail_in,
  input wire prot_trail_signal_degrade_in,
  // Selected output stream
  output reg [DATA_W-1:0] rx_data_out,
  output reg rx_frame_start_out,
  output reg rx_valid_out,
  input wire rx_ready_in,
  // Management setup and commands
  input wire protection_type_in,
  input wire revertive_in,
  input wire [3:0] wait_to_restore_interval_min_in,
  input wire [13:0] holdoff_ms_in,
  input wire [1:0] ext_cmd_in,
  // Status
  output reg on_protection_out,
  output reg wtr_running_out,
  output reg work_fail_out,
  output reg prot_fail_out
);

  localparam ST_WORK = 2'h0;
  localparam ST_PEND = 2'h1;
  localparam ST_PROT = 2'h2;
  localparam ST_WTR = 2'h3;

  // Three-stage synchroniser, first stage is read by the second and by the transmit edge detect.
  function [2:0] sync3;
    input [2:0] s;
    input d;
    begin
      sync3 = {s[1:0], d};
    end
  endfunction

  reg [2:0] tx_clk_s_q, tx_fs_s_q, work_clk_s_q, work_fs_s_q, prot_clk_s_q, prot_fs_s_q;
  reg [2:0] wsf_s_q, wtf_s_q, wtd_s_q, psf_s_q, ptf_s_q, ptd_s_q;
  reg [DATA_W-1:0] tx_d1_q, tx_d2_q, work_d1_q, work_d2_q, prot_d1_q, prot_d2_q;
  reg [1:0] state_q;
  reg [31:0] cyc_cnt_q;
  reg [23:0] ms_cnt_q;
  reg [DATA_W-1:0] work_hold_q, prot_hold_q;
  reg work_fs_hold_q, prot_fs_hold_q;
  reg prev_work_edge_q, prev_prot_edge_q;

  wire tx_edge = tx_clk_s_q[1] & tx_clk_s_q[2] & ~tx_clk_s_q[0] ? 1'b0 : (tx_clk_s_q[1] & ~tx_clk_s_q[2]);
  wire work_edge = work_clk_s_q[1] & ~work_clk_s_q[2];
  wire prot_edge = prot_clk_s_q[1] & ~prot_clk_s_q[2];
  wire w_sf = wsf_s_q[2];
  wire w_tf = wtf_s_q[2];
  wire w_td = wtd_s_q[2];
  wire p_sf = psf_s_q[2];
  wire p_tf = ptf_s_q[2];
  wire p_td = ptd_s_q[2];
  // Criterion per connection depends on the monitoring variant.
  wire work_bad = (protection_type_in == `PSP_PROT_INHERENT) ? w_sf : (w_tf | w_td);
  wire prot_bad = (protection_type_in == `PSP_PROT_INHERENT) ? p_sf : (p_tf | p_td);
  // Switching only pays off when protection is healthier than working.
  wire auto_to_prot = work_bad & ~prot_bad;
  wire auto_to_work = prot_bad & ~work_bad;
  wire [31:0] holdoff_cycles = BASE_SWITCH_CYCLES + holdoff_ms_in * MS_CYCLES;
  // The product is formed at full width; 15 minutes in ms still fits the 24-bit counter.
  wire [31:0] wtr_ms_full = wait_to_restore_interval_min_in * MIN_MS;
  wire [23:0] wtr_ms = wtr_ms_full[23:0];
  wire sel_prot = (state_q == ST_PROT) || (state_q == ST_WTR);

  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      tx_clk_s_q <= 3'h0;
      tx_fs_s_q <= 3'h0;
      work_clk_s_q <= 3'h0;
      work_fs_s_q <= 3'h0;
      prot_clk_s_q <= 3'h0;
      prot_fs_s_q <= 3'h0;
      wsf_s_q <= 3'h0;
      wtf_s_q <= 3'h0;
      wtd_s_q <= 3'h0;
      psf_s_q <= 3'h0;
      ptf_s_q <= 3'h0;
      ptd_s_q <= 3'h0;
      tx_d1_q <= {DATA_W{1'b0}};
      tx_d2_q <= {DATA_W{1'b0}};
      work_d1_q <= {DATA_W{1'b0}};
      work_d2_q <= {DATA_W{1'b0}};
      prot_d1_q <= {DATA_W{1'b0}};
      prot_d2_q <= {DATA_W{1'b0}};
    end
    else if (ce_in)
    begin
      tx_clk_s_q <= sync3(tx_clk_s_q, tx_clk_in);
      tx_fs_s_q <= sync3(tx_fs_s_q, tx_frame_start_in);
      work_clk_s_q <= sync3(work_clk_s_q, work_clk_in);
      work_fs_s_q <= sync3(work_fs_s_q, work_frame_start_in);
      prot_clk_s_q <= sync3(prot_clk_s_q, prot_clk_in);
      prot_fs_s_q <= sync3(prot_fs_s_q, prot_frame_start_in);
      wsf_s_q <= sync3(wsf_s_q, work_server_signal_fail_in);
      wtf_s_q <= sync3(wtf_s_q, work_trail_signal_fail_in);
      wtd_s_q <= sync3(wtd_s_q, work_trail_signal_degrade_in);
      psf_s_q <= sync3(psf_s_q, prot_server_signal_fail_in);
      ptf_s_q <= sync3(ptf_s_q, prot_trail_signal_fail_in);
      ptd_s_q <= sync3(ptd_s_q, prot_trail_signal_degrade_in);
      tx_d1_q <= tx_data_in;
      tx_d2_q <= tx_d1_q;
      work_d1_q <= work_data_in;
      work_d2_q <= work_d1_q;
      prot_d1_q <= prot_data_in;
      prot_d2_q <= prot_d1_q;
    end
  end

  // Permanent bridge: both outputs carry the same regenerated signal.
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      tx_work_data_out <= {DATA_W{1'b0}};
      tx_prot_data_out <= {DATA_W{1'b0}};
      tx_work_clk_out <= 1'b0;
      tx_prot_clk_out <= 1'b0;
      tx_work_frame_start_out <= 1'b0;
      tx_prot_frame_start_out <= 1'b0;
    end
    else if (ce_in)
    begin
      tx_work_clk_out <= tx_clk_s_q[2];
      tx_prot_clk_out <= tx_clk_s_q[2];
      if (tx_edge)
      begin
        tx_work_data_out <= tx_d2_q;
        tx_prot_data_out <= tx_d2_q;
        tx_work_frame_start_out <= tx_fs_s_q[2];
        tx_prot_frame_start_out <= tx_fs_s_q[2];
      end
    end
  end

  // Selector state machine; setup inputs are read every cycle in the states that use them.
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      state_q <= ST_WORK;
      cyc_cnt_q <= 32'h0;
      ms_cnt_q <= 24'h0;
    end
    else if (ce_in)
    begin
      case (state_q)
        ST_WORK:
        begin
          cyc_cnt_q <= 32'h0;
          if (ext_cmd_in == `PSP_CMD_FORCE_PROT || (ext_cmd_in == `PSP_CMD_MANUAL_PROT && !prot_bad))
            state_q <= ST_PROT;
          else if (ext_cmd_in != `PSP_CMD_FORCE_WORK && auto_to_prot)
            state_q <= ST_PEND;
        end
        ST_PEND:
        begin
          if (ext_cmd_in == `PSP_CMD_FORCE_PROT)
            state_q <= ST_PROT;
          else if (!auto_to_prot || ext_cmd_in == `PSP_CMD_FORCE_WORK)
            state_q <= ST_WORK;
          else if (cyc_cnt_q + 32'h1 >= holdoff_cycles)
            state_q <= ST_PROT;
          else
            cyc_cnt_q <= cyc_cnt_q + 32'h1;
        end
        ST_PROT:
        begin
          cyc_cnt_q <= 32'h0;
          ms_cnt_q <= 24'h0;
          if (ext_cmd_in == `PSP_CMD_FORCE_WORK || (ext_cmd_in == `PSP_CMD_CLEAR && auto_to_work))
            state_q <= ST_WORK;
          else if (ext_cmd_in == `PSP_CMD_CLEAR && revertive_in && !work_bad)
            state_q <= ST_WTR;
        end
        ST_WTR:
        begin
          if (ext_cmd_in == `PSP_CMD_FORCE_PROT || ext_cmd_in == `PSP_CMD_MANUAL_PROT || work_bad)
            state_q <= ST_PROT;
          else if (ext_cmd_in == `PSP_CMD_FORCE_WORK || prot_bad || ms_cnt_q >= wtr_ms)
            state_q <= ST_WORK;
          else if (cyc_cnt_q + 32'h1 >= MS_CYCLES)
          begin
            cyc_cnt_q <= 32'h0;
            ms_cnt_q <= ms_cnt_q + 24'h1;
          end
          else
            cyc_cnt_q <= cyc_cnt_q + 32'h1;
        end
        default:
          state_q <= ST_WORK;
      endcase
    end
  end

  // Capture each connection's word on its own recovered clock edge.
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      work_hold_q <= {DATA_W{1'b0}};
      prot_hold_q <= {DATA_W{1'b0}};
      work_fs_hold_q <= 1'b0;
      prot_fs_hold_q <= 1'b0;
      prev_work_edge_q <= 1'b0;
      prev_prot_edge_q <= 1'b0;
    end
    else if (ce_in)
    begin
      prev_work_edge_q <= work_edge & ~sel_prot;
      prev_prot_edge_q <= prot_edge & sel_prot;
      if (work_edge)
      begin
        work_hold_q <= work_d2_q;
        work_fs_hold_q <= work_fs_s_q[2];
      end
      if (prot_edge)
      begin
        prot_hold_q <= prot_d2_q;
        prot_fs_hold_q <= prot_fs_s_q[2];
      end
    end
  end

  wire sel_valid = prev_work_edge_q | prev_prot_edge_q;
  wire [DATA_W:0] sel_word = prev_prot_edge_q ? {prot_fs_hold_q, prot_hold_q} :
                                                {work_fs_hold_q, work_hold_q};
  wire buf_out_valid;
  wire [DATA_W:0] buf_out_data;
  wire out_take = !rx_valid_out || rx_ready_in;

  psp_skid_buffer #(
    .WIDTH(DATA_W + 1)
  ) u_buf (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .in_valid_in(sel_valid),
    .in_data_in(sel_word),
    .in_ready_out(),
    .out_valid_out(buf_out_valid),
    .out_data_out(buf_out_data),
    .out_ready_in(out_take)
  );

  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      rx_data_out <= {DATA_W{1'b0}};
      rx_frame_start_out <= 1'b0;
      rx_valid_out <= 1'b0;
      on_protection_out <= 1'b0;
      wtr_running_out <= 1'b0;
      work_fail_out <= 1'b0;
      prot_fail_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (out_take)
      begin
        rx_valid_out <= buf_out_valid;
        rx_data_out <= buf_out_data[DATA_W-1:0];
        rx_frame_start_out <= buf_out_data[DATA_W];
      end
      on_protection_out <= sel_prot;
      wtr_running_out <= (state_q == ST_WTR);
      work_fail_out <= work_bad;
      prot_fail_out <= prot_bad;
    end
  end

endmodule

`default_nettype wire

// ==== src/psp_skid_buffer.v ====
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes a single clock domain and a synchronous active-high reset.
*/
`default_nettype none

module psp_skid_buffer #(
  parameter WIDTH = 9
) (
  // Clock and reset
  input wire clk_sys_in,
  input wire rst_in,
  input wire ce_in,
  // Fill side
  input wire in_valid_in,
  input wire [WIDTH-1:0] in_data_in,
  output wire in_ready_out,
  // Drain side
  output wire out_valid_out,
  output wire [WIDTH-1:0] out_data_out,
  input wire out_ready_in
);

  reg [WIDTH-1:0] mem_q [0:1];
  reg wr_ptr_q;
  reg rd_ptr_q;
  reg [1:0] count_q;
  wire push;
  wire pop;

  assign in_ready_out = (count_q != 2'h2);
  assign out_valid_out = (count_q != 2'h0);
  assign out_data_out = mem_q[rd_ptr_q];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end
    else if (ce_in)
    begin
      if (push)
      begin
        mem_q[wr_ptr_q] <= in_data_in;
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      if (push && !pop)
        count_q <= count_q + 2'h1;
      else if (pop && !push)
        count_q <= count_q - 2'h1;
    end
  end

endmodule

`default_nettype wire
